// File: include/cmfs_regs.vh
// cmfs_regs.vh: offsets, field positions and reset values of the fault status bank.
// assumes a 16-bit register port addressed by plain register index.
`ifndef CMFS_REGS_VH
`define CMFS_REGS_VH

`define CMFS_ADDR_W            11
`define CMFS_LINK_FAULT_ADDR   11'h423
`define CMFS_MEAS_FAULT_ADDR   11'h424
`define CMFS_RESET_VALUE       16'h0000

// link fault register fields
`define CMFS_FRAME_ERR_BIT     0
`define CMFS_CRC_ERR_BIT       1
`define CMFS_CNT_FULL_BIT      2
`define CMFS_TIMEOUT_BIT       3
`define CMFS_RSP_LEN_BIT       4
`define CMFS_CNT_LSB           8
`define CMFS_CNT_MSB           15
`define CMFS_CNT_MAX           8'hFF

// measurement fault register fields
`define CMFS_PRIM_CAL_BIT      0
`define CMFS_SEC_CAL_BIT       1
`define CMFS_SYNC_BIT          2

`endif

// File: core/cmfs_flag.v
// cmfs_flag.v: one sticky fault flag, set by hardware, cleared by writing 1.
// assumes set and clear both come from logic on clk.
`timescale 1ns/1ps
`default_nettype none

module cmfs_flag
(
  // clock and reset
  input  wire clk,
  input  wire nrst,
  // set and clear
  input  wire set_evt,
  input  wire clr_evt,
  // state
  output reg  flag_reg
);

  // set beats clear so an event landing on a clear is kept
  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      flag_reg <= 1'b0;
    else if (set_evt)
      flag_reg <= 1'b1;
    else if (clr_evt)
      flag_reg <= 1'b0;
  end

endmodule // cmfs_flag

`default_nettype wire

// File: core/cmfs_top.v
// cmfs_top.v: link and measurement fault status registers with the link error counter.
// assumes fault strobes are one-cycle pulses from detectors on clk; the register port
// is a simple synchronous read/write strobe pair on the same clock.
//
// How it works
// (RL1) count frame and CRC errors in high byte
// (RL2) counter stops at 0xFF, never wraps
// (RL3) nonzero write to the count byte clears count; zero count byte keeps
// (RL4) count survives sleep; only reset or a count-byte clear write clears it
// (RL5) full flag bit 2 at max count
// (RL6) response length mismatch sets bit 4
// (RL7) link timeout sets bit 3, sticky
// (RL8) CRC failure sets bit 1
// (RL9) frame format error sets bit 0
// (RL10) reserved bits read zero, writes ignored
// (RL11) measurement sync loss sets bit 2
// (RL12) secondary calibration corruption sets bit 1
// (RL13) primary calibration corruption sets bit 0
// (RL14) everything resets to zero
// (RL15) event beats same-cycle clear
`timescale 1ns/1ps
`default_nettype none
`include "cmfs_regs.vh"

module cmfs_top
(
  // clock and reset
  input  wire        clk,
  input  wire        nrst,
  // register port
  input  wire [10:0] reg_addr,
  input  wire        reg_wr,
  input  wire        reg_rd,
  input  wire [15:0] reg_wdata,
  output reg  [15:0] reg_rdata_reg,
  output reg         reg_rvalid_reg,
  // link fault events
  input  wire        link_frame_error_evt,
  input  wire        link_crc_error_evt,
  input  wire        link_timeout_evt,
  input  wire        response_length_error_evt,
  // measurement fault events
  input  wire        measurement_sync_fault_evt,
  input  wire        secondary_calibration_fault_evt,
  input  wire        primary_calibration_fault_evt,
  // sleep indication, counter keeps its value across it
  input  wire        sleep_mode,
  // live status
  output reg  [15:0] link_fault_status_reg,
  output reg  [15:0] measurement_fault_status_reg
);

  // write decode
  wire        wr_link;
  wire        wr_meas;
  wire [15:0] clr_link;
  wire [15:0] clr_meas;
  assign wr_link  = reg_wr && (reg_addr == `CMFS_LINK_FAULT_ADDR);
  assign wr_meas  = reg_wr && (reg_addr == `CMFS_MEAS_FAULT_ADDR);
  assign clr_link = wr_link ? reg_wdata : 16'h0000;
  assign clr_meas = wr_meas ? reg_wdata : 16'h0000;

  // link error counter
  reg  [7:0] link_error_count_reg;
  reg  [7:0] link_error_count_next;
  wire       count_evt;
  wire       count_clr;
  wire       count_sat;
  assign count_evt = link_frame_error_evt | link_crc_error_evt; // see RL1
  assign count_clr = |clr_link[`CMFS_CNT_MSB:`CMFS_CNT_LSB]; // see RL3
  assign count_sat = (link_error_count_reg == `CMFS_CNT_MAX);

  // count and clear in one cycle resolve to a count of one so the error is kept
  always @*
  begin
    link_error_count_next = link_error_count_reg;
    if (count_clr)
      link_error_count_next = count_evt ? 8'h01 : 8'h00; // see RL3 see RL15
    else if (count_evt && !count_sat)
      link_error_count_next = link_error_count_reg + 8'h01; // see RL1 see RL2
  end

  // sleep_mode is not looked at, so the count is held straight through it
  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      link_error_count_reg <= 8'h00; // see RL14
    else
      link_error_count_reg <= link_error_count_next; // see RL4
  end

  // full flag raised on the cycle the counter arrives at its maximum
  wire full_set;
  assign full_set = (link_error_count_next == `CMFS_CNT_MAX) && !count_sat; // see RL5

  // sticky link and measurement flags
  wire [7:0] set_vec;
  wire [7:0] clr_vec;
  wire [7:0] flag_q;
  assign set_vec = {measurement_sync_fault_evt,      // see RL11
                    secondary_calibration_fault_evt, // see RL12
                    primary_calibration_fault_evt,   // see RL13
                    response_length_error_evt,       // see RL6
                    link_timeout_evt,                // see RL7
                    full_set,
                    link_crc_error_evt,              // see RL8
                    link_frame_error_evt};           // see RL9
  assign clr_vec = {clr_meas[`CMFS_SYNC_BIT],
                    clr_meas[`CMFS_SEC_CAL_BIT],
                    clr_meas[`CMFS_PRIM_CAL_BIT],
                    clr_link[`CMFS_RSP_LEN_BIT],
                    clr_link[`CMFS_TIMEOUT_BIT],
                    clr_link[`CMFS_CNT_FULL_BIT],
                    clr_link[`CMFS_CRC_ERR_BIT],
                    clr_link[`CMFS_FRAME_ERR_BIT]};

  genvar gi;
  generate
    for (gi = 0; gi < 8; gi = gi + 1)
    begin : g_flag
      cmfs_flag u_flag
      (
        .clk      (clk),
        .nrst     (nrst),
        .set_evt  (set_vec[gi]),
        .clr_evt  (clr_vec[gi]),
        .flag_reg (flag_q[gi])   // see RL15
      );
    end
  endgenerate

  // assembled register images; reserved bits are constant zero
  wire [15:0] link_image;
  wire [15:0] meas_image;
  assign link_image = {link_error_count_next, 3'b000, flag_q[4:0]}; // see RL10
  assign meas_image = {13'h0000, flag_q[7:5]};                      // see RL10

  // status mirrors load the flags' next value so they track the flags with no lag; counter image uses next so it aligns
  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      link_fault_status_reg        <= `CMFS_RESET_VALUE; // see RL14
      measurement_fault_status_reg <= `CMFS_RESET_VALUE; // see RL14
    end
    else
    begin
      link_fault_status_reg        <= {link_error_count_next, 3'b000,
                                       (flag_q[4:0] | set_vec[4:0]) & ~(clr_vec[4:0] & ~set_vec[4:0])};
      measurement_fault_status_reg <= {13'h0000,
                                       (flag_q[7:5] | set_vec[7:5]) & ~(clr_vec[7:5] & ~set_vec[7:5])};
    end
  end

  // read port: data one cycle after the strobe; unmapped addresses read zero
  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      reg_rdata_reg  <= 16'h0000;
      reg_rvalid_reg <= 1'b0;
    end
    else
    begin
      reg_rvalid_reg <= reg_rd;
      if (reg_rd && reg_addr == `CMFS_LINK_FAULT_ADDR)
        reg_rdata_reg <= {link_error_count_reg, 3'b000, flag_q[4:0]};
      else if (reg_rd && reg_addr == `CMFS_MEAS_FAULT_ADDR)
        reg_rdata_reg <= {13'h0000, flag_q[7:5]};
      else if (reg_rd)
        reg_rdata_reg <= 16'h0000;
    end
  end

  // images kept for width checks of the field layout
  wire unused_ok;
  assign unused_ok = &{1'b0, link_image, meas_image, sleep_mode};

endmodule // cmfs_top

`default_nettype wire

// File: bench/cmfs_top_asserts.sv
// cmfs_top_asserts.sv: port-level timing checks for the fault status bank.
// assumes one clock and an async active-low reset; bound onto cmfs_top.
`timescale 1ns/1ps
`default_nettype none
module cmfs_asserts
(
  // clock, reset, register port
  input wire logic        clk,
  input wire logic        nrst,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic        reg_rvalid_reg,
  // fault events
  input wire logic        link_crc_error_evt,
  input wire logic        link_timeout_evt,
  input wire logic        response_length_error_evt,
  input wire logic        measurement_sync_fault_evt,
  input wire logic        primary_calibration_fault_evt,
  // live status
  input wire logic [15:0] link_fault_status_reg,
  input wire logic [15:0] measurement_fault_status_reg
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  // mirror sets on the edge after the event, same as the flag; the window allows one spare cycle
  crc_flag_a: assert property (link_crc_error_evt |-> ##[1:2] link_fault_status_reg[1])
    else $error("crc flag not set");
  timeout_flag_a: assert property (link_timeout_evt |-> ##[1:2] link_fault_status_reg[3])
    else $error("timeout flag not set");
  rsp_len_a: assert property (response_length_error_evt |-> ##[1:2] link_fault_status_reg[4])
    else $error("length flag not set");
  sync_flag_a: assert property (measurement_sync_fault_evt |-> ##[1:2] measurement_fault_status_reg[2])
    else $error("sync flag not set");
  prim_cal_a: assert property (primary_calibration_fault_evt |-> ##[1:2] measurement_fault_status_reg[0])
    else $error("primary flag not set");
  reserved_zero_a: assert property (link_fault_status_reg[7:5] == 3'h0 && measurement_fault_status_reg[15:3] == 13'h0000)
    else $error("reserved bits set");
  read_valid_a: assert property (reg_rvalid_reg == $past(reg_rd))
    else $error("read valid timing wrong");
  // a full count may only drop through a write
  count_sat_a: assert property (link_fault_status_reg[15:8] == 8'hFF && !reg_wr && !$past(reg_wr) |=> link_fault_status_reg[15:8] == 8'hFF)
    else $error("count left saturation");
endmodule // cmfs_asserts
bind cmfs_top cmfs_asserts u_chk (.*);
`default_nettype wire

// File: bench/cmfs_top_tb.sv
// cmfs_top_tb.sv: self-checking bench for the fault status bank.
// assumes one-cycle read latency and set-wins-over-clear in the design.
`timescale 1ns/1ps
`default_nettype none
module cmfs_top_tb;
  logic        clk = 1'b0;
  logic        nrst = 1'b0;
  logic [10:0] addr = 11'h000;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic [15:0] wd = 16'h0000;
  logic [6:0]  ev = 7'h00;
  logic        slp = 1'b0;
  wire  [15:0] rdata, lfs, mfs;
  wire         rvalid;
  int          fails = 0;
  int          total_checks = 0;
  cmfs_top dut (.clk(clk), .nrst(nrst), .reg_addr(addr), .reg_wr(wr), .reg_rd(rd),
    .reg_wdata(wd), .reg_rdata_reg(rdata), .reg_rvalid_reg(rvalid),
    .link_frame_error_evt(ev[0]), .link_crc_error_evt(ev[1]), .link_timeout_evt(ev[2]),
    .response_length_error_evt(ev[3]), .measurement_sync_fault_evt(ev[4]),
    .secondary_calibration_fault_evt(ev[5]), .primary_calibration_fault_evt(ev[6]),
    .sleep_mode(slp), .link_fault_status_reg(lfs), .measurement_fault_status_reg(mfs));
  initial forever #4 clk = ~clk;
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      fails++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // tasks enter just after an edge and leave 1 ns after one
  task automatic wrt(input logic [10:0] a, input logic [15:0] d);
    addr = a;
    wd = d;
    wr = 1'b1;
    @(posedge clk);
    #1 wr = 1'b0;
    // idle edge so a following call never lowers and raises a strobe at once
    @(posedge clk);
    #1;
  endtask
  // read, then compare data and the live mirror
  task automatic rdc(input logic [10:0] a, input logic [15:0] e);
    addr = a;
    rd = 1'b1;
    @(posedge clk);
    #1 rd = 1'b0;
    chk({15'h0000, rvalid}, 16'h0001);
    chk(rdata, e);
    if (a == 11'h423) chk(lfs, e);
    if (a == 11'h424) chk(mfs, e);
    // idle edge keeps back-to-back reads from re-raising rd in one step
    @(posedge clk);
    #1;
  endtask
  task automatic pulse(input logic [6:0] m, input int n);
    ev = m;
    repeat (n) @(posedge clk);
    #1 ev = 7'h00;
  endtask
  task automatic t_link;
    rdc(11'h425, 16'h0000);
    pulse(7'h01, 1);
    rdc(11'h423, 16'h0101);
    wrt(11'h423, 16'h0001);
    rdc(11'h423, 16'h0100);
    pulse(7'h03, 1);
    rdc(11'h423, 16'h0203);
    pulse(7'h0C, 1);
    rdc(11'h423, 16'h021B);
    wrt(11'h423, 16'hFFFF);
    rdc(11'h423, 16'h0000);
    $display("test link done");
  endtask
  task automatic t_meas;
    pulse(7'h70, 1);
    rdc(11'h424, 16'h0007);
    wrt(11'h424, 16'hFFFA);
    rdc(11'h424, 16'h0005);
    wrt(11'h424, 16'h0005);
    rdc(11'h424, 16'h0000);
    $display("test meas done");
  endtask
  // fill the count across sleep, saturate, race a clear, then reset again
  task automatic t_sat;
    slp = 1'b1;
    pulse(7'h02, 254);
    slp = 1'b0;
    rdc(11'h423, 16'hFE02);
    pulse(7'h02, 3);
    rdc(11'h423, 16'hFF06);
    wrt(11'h423, 16'h0004);
    rdc(11'h423, 16'hFF02);
    ev = 7'h02;
    wrt(11'h423, 16'h0002);
    ev = 7'h00;
    wrt(11'h425, 16'hFFFF);
    rdc(11'h423, 16'hFF02);
    nrst = 1'b0;
    @(posedge clk);
    #1 nrst = 1'b1;
    rdc(11'h423, 16'h0000);
    rdc(11'h424, 16'h0000);
    $display("test sat done");
  endtask
  task automatic end_of_test;
    $display("checks %0d fails %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial
  begin
    repeat (20) @(posedge clk);
    #1 nrst = 1'b1;
    t_link;
    t_meas;
    t_sat;
    end_of_test;
  end
endmodule // cmfs_top_tb
`default_nettype wire
